// *** src/css_map.svh ***
`ifndef CSS_MAP_SVH
`define CSS_MAP_SVH

`define CSS_OFF_FUSE            8'h00
`define CSS_OFF_TRIM            8'h04
`define CSS_OFF_PRESCALE        8'h08
`define CSS_OFF_CTRL            8'h0c
`define CSS_OFF_STATUS          8'h10

`define CSS_CTRL_RESTART        0
`define CSS_CTRL_SLEEP          1
`define CSS_STAT_RUN            3
`define CSS_STAT_BADSRC         4

`define CSS_CLOCK_SOURCE_SELECT_FUSES_EXT           4'h0
`define CSS_CLOCK_SOURCE_SELECT_FUSES_RC            4'h2
`define CSS_CLOCK_SOURCE_SELECT_FUSES_128K          4'h3
`define CSS_CLOCK_SOURCE_SELECT_FUSES_LF_FAST       4'h6
`define CSS_CLOCK_SOURCE_SELECT_FUSES_LF_SLOW       4'h7

`define CSS_SUT_SHORT           2'h0
`define CSS_SUT_MID             2'h1
`define CSS_SUT_LONG            2'h2

`define CSS_RST_CLOCK_SOURCE_SELECT_FUSES           4'h2
`define CSS_RST_SUT             2'h2
`define CSS_RST_DIV8            1'h1
`define CSS_RST_RSTDIS          1'h0

`define CSS_PS_DIV1             4'h0
`define CSS_PS_DIV8             4'h3
`define CSS_PS_MAX              4'h8

`define CSS_CK_RST_LF           16'h0004
`define CSS_CK_RST_STD          16'h000e
`define CSS_CK_WAKE_STD         16'h0006
`define CSS_CK_WAKE_LF_FAST     16'h0400
`define CSS_CK_WAKE_LF_SLOW     16'h8000

`define CSS_WDT_KHZ             32'h0080
`define CSS_T_4P1MS_US          32'h1004
`define CSS_T_4MS_US            32'h0fa0
`define CSS_T_65MS_US           32'hfde8
`define CSS_T_64MS_US           32'hfa00
`define CSS_US_PER_MS           32'h03e8

`define CSS_RESP_OKAY           2'h0
`define CSS_RESP_SLVERR         2'h2

`endif

// *** src/css_pkg.sv ***
package css_pkg;

  typedef struct packed {
    logic       resetPinDisableFuse;
    logic       divideByEightFuse;
    logic [1:0] startupTimeFuses;
    logic [3:0] clockSourceSelectFuses;
  } css_fuse_t;

  typedef enum logic [2:0] {
    ST_START,
    ST_RESET_DELAY,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE_DELAY,
    ST_BAD
  } css_state_t;

  typedef enum logic [1:0] {
    SRC_WATCH,
    SRC_RC,
    SRC_128K,
    SRC_EXT
  } css_src_t;

endpackage

// *** src/css_sync.sv ***
`timescale 1ns/1ps
module css_sync
  import css_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          stage1_ff[i] <= 1'b0;
          stage2_ff[i] <= 1'b0;
        end else begin
          stage1_ff[i] <= asyncIn[i];
          stage2_ff[i] <= stage1_ff[i];
        end
      end
    end
  endgenerate

  assign syncOut = stage2_ff;

endmodule

// *** src/css_delay_counter.sv ***
`timescale 1ns/1ps
module css_delay_counter
  import css_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic             clear,
  input  wire logic             tick,
  input  wire logic [CNT_W-1:0] target,
  output logic                  done
);

  logic [CNT_W-1:0] count_ff;

  // Counting stops at the target so the count cannot wrap while a
  // slow oscillator keeps ticking after the delay has expired.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count_ff <= '0;
    end else if (clear) begin
      count_ff <= '0;
    end else if (tick && !done) begin
      count_ff <= count_ff + 1'b1;
    end
  end

  assign done = (count_ff >= target);

endmodule

// *** src/css_clock_startup.sv ***
`timescale 1ns/1ps
`include "css_map.svh"
module css_clock_startup
  import css_pkg::*;
#(
  parameter int CNT_W        = 16,
  parameter int WDT_CYC_65MS = (`CSS_T_65MS_US * `CSS_WDT_KHZ + `CSS_US_PER_MS - 1)
                               / `CSS_US_PER_MS,
  parameter int WDT_CYC_64MS = (`CSS_T_64MS_US * `CSS_WDT_KHZ + `CSS_US_PER_MS - 1)
                               / `CSS_US_PER_MS,
  parameter int SRC_CYC_32K  = `CSS_CK_WAKE_LF_SLOW
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  input  wire logic        timerOscillatorPin,
  input  wire logic        rcOscillator,
  input  wire logic        lowPowerOscillator,
  input  wire logic        crystalInputPin,
  input  wire logic        watchdogOscillator,
  input  wire logic        wakePin,
  input  wire logic [7:0]  factoryTrim,
  output logic [3:0]       oscEnable,
  output logic [7:0]       oscillatorTrimValue,
  output logic [3:0]       prescalerDivideSelect,
  output logic             sysClkRun,
  output logic             sysTick,
  output logic             coreReset
);

  localparam int WDT_CYC_4P1MS = (`CSS_T_4P1MS_US * `CSS_WDT_KHZ + `CSS_US_PER_MS - 1)
                                 / `CSS_US_PER_MS;
  localparam int WDT_CYC_4MS   = (`CSS_T_4MS_US * `CSS_WDT_KHZ + `CSS_US_PER_MS - 1)
                                 / `CSS_US_PER_MS;

  generate
    if (CNT_W < 16 || WDT_CYC_65MS >= (1 << CNT_W) || WDT_CYC_64MS >= (1 << CNT_W)
        || SRC_CYC_32K >= (1 << CNT_W) || SRC_CYC_32K < 1 || WDT_CYC_64MS < 1
        || WDT_CYC_65MS < 1) begin : g_bad_param
      $error("css_clock_startup: delay counts do not fit the counter width");
    end
  endgenerate

  css_fuse_t        fuse_ff;
  css_state_t       state_ff;
  css_src_t         activeSrc_ff;
  logic             srcOk_ff;
  logic [7:0]       trim_ff;
  logic [3:0]       prescale_ff;
  logic [CNT_W-1:0] cycTarget_ff;
  logic [CNT_W-1:0] msTarget_ff;
  logic [CNT_W-1:0] wakeTarget_ff;
  logic [3:0]       oscEnable_ff;
  logic             sysClkRun_ff;
  logic             sysTick_ff;
  logic             coreReset_ff;
  logic [7:0]       divCnt_ff;
  logic [4:0]       pinLast_ff;

  logic             awready_ff;
  logic             wready_ff;
  logic             awHave_ff;
  logic             wHave_ff;
  logic [7:0]       awAddr_ff;
  logic [31:0]      wData_ff;
  logic [3:0]       wStrb_ff;
  logic             bvalid_ff;
  logic [1:0]       bresp_ff;
  logic             arready_ff;
  logic             rvalid_ff;
  logic [31:0]      rdata_ff;
  logic [1:0]       rresp_ff;

  logic [4:0]       pinSync;
  logic [4:0]       pinRise;
  logic             srcEdge;
  logic             wdtEdge;
  logic             cycDone;
  logic             msDone;
  logic             cntClear;
  logic             doWrite;
  logic             wrLane0;
  logic             restartReq;
  logic             sleepReq;
  css_src_t         nxt_src;
  logic             nxt_srcOk;
  logic [CNT_W-1:0] nxt_cycTarget;
  logic [CNT_W-1:0] nxt_msTarget;
  logic [CNT_W-1:0] nxt_wakeTarget;
  logic [3:0]       psClamp;
  logic [8:0]       psShift;
  logic [7:0]       divMask;
  logic [31:0]      nxt_rdata;
  logic             nxt_rdOk;

  // Oscillators and the wake pin live outside mclk and are synchronised.
  css_sync #(
    .WIDTH (5)
  ) u_sync (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .asyncIn ({wakePin, watchdogOscillator, crystalInputPin, lowPowerOscillator,
               rcOscillator}),
    .syncOut (pinSync)
  );

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pinLast_ff <= 5'h00;
    end else begin
      pinLast_ff <= pinSync;
    end
  end

  assign pinRise = pinSync & ~pinLast_ff;
  assign wdtEdge = pinRise[3];

  // The watch crystal on the timer pin is not synchronised with the rest, so
  // its own pair of flip-flops lives here in a second instance.
  logic watchSync;
  logic watchLast_ff;

  css_sync #(
    .WIDTH (1)
  ) u_sync_watch (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .asyncIn (timerOscillatorPin),
    .syncOut (watchSync)
  );

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      watchLast_ff <= 1'b0;
    end else begin
      watchLast_ff <= watchSync;
    end
  end

  always_comb begin
    unique case (activeSrc_ff)
      SRC_WATCH: srcEdge = watchSync & ~watchLast_ff;
      SRC_RC:    srcEdge = pinRise[0];
      SRC_128K:  srcEdge = pinRise[1];
      SRC_EXT:   srcEdge = pinRise[2];
    endcase
  end

  // Decode of the fuse image into the source and all three delay targets.
  always_comb begin
    nxt_src        = SRC_RC;
    nxt_srcOk      = 1'b1;
    nxt_cycTarget  = CNT_W'(`CSS_CK_RST_STD);
    nxt_wakeTarget = CNT_W'(`CSS_CK_WAKE_STD);
    nxt_msTarget   = '0;
    case (fuse_ff.clockSourceSelectFuses)
      `CSS_CLOCK_SOURCE_SELECT_FUSES_EXT:  nxt_src = SRC_EXT;
      `CSS_CLOCK_SOURCE_SELECT_FUSES_RC:   nxt_src = SRC_RC;
      `CSS_CLOCK_SOURCE_SELECT_FUSES_128K: nxt_src = SRC_128K;
      `CSS_CLOCK_SOURCE_SELECT_FUSES_LF_FAST, `CSS_CLOCK_SOURCE_SELECT_FUSES_LF_SLOW: begin
        nxt_src       = SRC_WATCH;
        nxt_cycTarget = CNT_W'(`CSS_CK_RST_LF);
        nxt_wakeTarget = fuse_ff.clockSourceSelectFuses[0] ? CNT_W'(SRC_CYC_32K)
                                                         : CNT_W'(`CSS_CK_WAKE_LF_FAST);
      end
      default: nxt_srcOk = 1'b0;
    endcase
    case (fuse_ff.startupTimeFuses)
      `CSS_SUT_SHORT: begin
        if (fuse_ff.resetPinDisableFuse && (nxt_src == SRC_RC || nxt_src == SRC_128K)) begin
          nxt_msTarget = CNT_W'(WDT_CYC_4P1MS);
        end
      end
      `CSS_SUT_MID: begin
        nxt_msTarget = (nxt_src == SRC_128K) ? CNT_W'(WDT_CYC_4MS)
                                             : CNT_W'(WDT_CYC_4P1MS);
      end
      // The reserved code takes the longest delay, which is always safe.
      default: begin
        nxt_msTarget = (nxt_src == SRC_128K) ? CNT_W'(WDT_CYC_64MS)
                                             : CNT_W'(WDT_CYC_65MS);
      end
    endcase
  end

  assign cntClear = (state_ff == ST_START) || (state_ff == ST_SLEEP);

  css_delay_counter #(
    .CNT_W (CNT_W)
  ) u_cyc_cnt (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .clear  (cntClear),
    .tick   (srcEdge),
    .target ((state_ff == ST_WAKE_DELAY) ? wakeTarget_ff : cycTarget_ff),
    .done   (cycDone)
  );

  // The millisecond time-out runs on the watchdog oscillator, whatever
  // source the core is clocked from.
  css_delay_counter #(
    .CNT_W (CNT_W)
  ) u_ms_cnt (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .clear  (cntClear),
    .tick   (wdtEdge),
    .target (msTarget_ff),
    .done   (msDone)
  );

  assign doWrite    = awHave_ff && wHave_ff && !bvalid_ff;
  assign wrLane0    = doWrite && wStrb_ff[0];
  assign restartReq = wrLane0 && (awAddr_ff == `CSS_OFF_CTRL)
                      && wData_ff[`CSS_CTRL_RESTART];
  assign sleepReq   = wrLane0 && (awAddr_ff == `CSS_OFF_CTRL) && wData_ff[`CSS_CTRL_SLEEP];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_START;
    end else if (restartReq) begin
      state_ff <= ST_START;
    end else begin
      unique case (state_ff)
        ST_START:       state_ff <= nxt_srcOk ? ST_RESET_DELAY : ST_BAD;
        ST_RESET_DELAY: state_ff <= (cycDone && msDone) ? ST_RUN : ST_RESET_DELAY;
        ST_RUN:         state_ff <= sleepReq ? ST_SLEEP : ST_RUN;
        ST_SLEEP:       state_ff <= pinSync[4] ? ST_WAKE_DELAY : ST_SLEEP;
        ST_WAKE_DELAY:  state_ff <= cycDone ? ST_RUN : ST_WAKE_DELAY;
        ST_BAD:         state_ff <= ST_BAD;
      endcase
    end
  end

  // Targets and the source are frozen at the start of each reset sequence,
  // so a fuse write only takes effect on the next restart.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      activeSrc_ff  <= SRC_RC;
      srcOk_ff      <= 1'b1;
      cycTarget_ff  <= '0;
      msTarget_ff   <= '0;
      wakeTarget_ff <= '0;
      oscEnable_ff  <= 4'h0;
    end else if (state_ff == ST_START) begin
      activeSrc_ff  <= nxt_src;
      srcOk_ff      <= nxt_srcOk;
      cycTarget_ff  <= nxt_cycTarget;
      msTarget_ff   <= nxt_msTarget;
      wakeTarget_ff <= nxt_wakeTarget;
      oscEnable_ff  <= nxt_srcOk ? (4'h1 << nxt_src) : 4'h0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sysClkRun_ff <= 1'b0;
      coreReset_ff <= 1'b1;
    end else begin
      sysClkRun_ff <= (state_ff == ST_RUN) && !sleepReq && !restartReq;
      coreReset_ff <= (state_ff == ST_START) || (state_ff == ST_RESET_DELAY)
                      || (state_ff == ST_BAD) || restartReq;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fuse_ff <= '{resetPinDisableFuse:    `CSS_RST_RSTDIS,
                   divideByEightFuse:      `CSS_RST_DIV8,
                   startupTimeFuses:       `CSS_RST_SUT,
                   clockSourceSelectFuses: `CSS_RST_CLOCK_SOURCE_SELECT_FUSES};
    end else if (wrLane0 && awAddr_ff == `CSS_OFF_FUSE) begin
      fuse_ff <= wData_ff[7:0];
    end
  end

  // The factory value is a port, so it is loaded by the first clocked
  // cycle of the sequence rather than by the asynchronous reset.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      trim_ff <= 8'h00;
    end else if (state_ff == ST_START) begin
      trim_ff <= factoryTrim;
    end else if (wrLane0 && awAddr_ff == `CSS_OFF_TRIM) begin
      trim_ff <= wData_ff[7:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prescale_ff <= `CSS_PS_DIV1;
    end else if (state_ff == ST_START) begin
      prescale_ff <= fuse_ff.divideByEightFuse ? `CSS_PS_DIV8 : `CSS_PS_DIV1;
    end else if (wrLane0 && awAddr_ff == `CSS_OFF_PRESCALE) begin
      prescale_ff <= wData_ff[3:0];
    end
  end

  // Reserved prescaler codes behave as the largest legal division.
  assign psClamp = (prescale_ff > `CSS_PS_MAX) ? `CSS_PS_MAX : prescale_ff;
  assign psShift = 9'h001 << psClamp;
  assign divMask = 8'(psShift - 9'h001);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_ff  <= 8'h00;
      sysTick_ff <= 1'b0;
    end else if (state_ff != ST_RUN) begin
      divCnt_ff  <= 8'h00;
      sysTick_ff <= 1'b0;
    end else begin
      sysTick_ff <= srcEdge && (divCnt_ff == divMask);
      if (srcEdge) begin
        divCnt_ff <= (divCnt_ff >= divMask) ? 8'h00 : divCnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      awready_ff <= 1'b1;
      awHave_ff  <= 1'b0;
      awAddr_ff  <= 8'h00;
    end else if (s_axi_awvalid && awready_ff) begin
      awready_ff <= 1'b0;
      awHave_ff  <= 1'b1;
      awAddr_ff  <= {s_axi_awaddr[7:2], 2'h0};
    end else if (doWrite) begin
      awHave_ff <= 1'b0;
    end else if (bvalid_ff && s_axi_bready) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wready_ff <= 1'b1;
      wHave_ff  <= 1'b0;
      wData_ff  <= 32'h0000_0000;
      wStrb_ff  <= 4'h0;
    end else if (s_axi_wvalid && wready_ff) begin
      wready_ff <= 1'b0;
      wHave_ff  <= 1'b1;
      wData_ff  <= s_axi_wdata;
      wStrb_ff  <= s_axi_wstrb;
    end else if (doWrite) begin
      wHave_ff <= 1'b0;
    end else if (bvalid_ff && s_axi_bready) begin
      wready_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `CSS_RESP_OKAY;
    end else if (doWrite) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (awAddr_ff <= `CSS_OFF_CTRL) ? `CSS_RESP_OKAY : `CSS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rdOk  = 1'b1;
    case ({s_axi_araddr[7:2], 2'h0})
      `CSS_OFF_FUSE:     nxt_rdata[7:0] = fuse_ff;
      `CSS_OFF_TRIM:     nxt_rdata[7:0] = trim_ff;
      `CSS_OFF_PRESCALE: nxt_rdata[3:0] = prescale_ff;
      `CSS_OFF_CTRL:     nxt_rdata = 32'h0000_0000;
      `CSS_OFF_STATUS: begin
        nxt_rdata[2:0]              = state_ff;
        nxt_rdata[`CSS_STAT_RUN]    = sysClkRun_ff;
        nxt_rdata[`CSS_STAT_BADSRC] = !srcOk_ff;
        nxt_rdata[6:5]              = activeSrc_ff;
      end
      default: nxt_rdOk = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= `CSS_RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rdOk ? `CSS_RESP_OKAY : `CSS_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  assign s_axi_awready         = awready_ff;
  assign s_axi_wready          = wready_ff;
  assign s_axi_bvalid          = bvalid_ff;
  assign s_axi_bresp           = bresp_ff;
  assign s_axi_arready         = arready_ff;
  assign s_axi_rvalid          = rvalid_ff;
  assign s_axi_rdata           = rdata_ff;
  assign s_axi_rresp           = rresp_ff;
  assign oscEnable             = oscEnable_ff;
  assign oscillatorTrimValue   = trim_ff;
  assign prescalerDivideSelect = prescale_ff;
  assign sysClkRun             = sysClkRun_ff;
  assign sysTick               = sysTick_ff;
  assign coreReset             = coreReset_ff;

endmodule

// *** bench/css_osc_model.sv ***
`timescale 1ns/1ps
module css_osc_model (
  output logic timerOscillatorPin,
  output logic rcOscillator,
  output logic lowPowerOscillator,
  output logic crystalInputPin,
  output logic watchdogOscillator
);
  initial begin
    {timerOscillatorPin, rcOscillator, lowPowerOscillator} = '0;
    {crystalInputPin, watchdogOscillator} = '0;
  end
  // Fixed rates keep every start-up count predictable for the bench.
  always #110 timerOscillatorPin = ~timerOscillatorPin;
  always #50 rcOscillator = ~rcOscillator;
  always #75 lowPowerOscillator = ~lowPowerOscillator;
  always #60 crystalInputPin = ~crystalInputPin;
  always #100 watchdogOscillator = ~watchdogOscillator;
endmodule

// *** bench/css_clock_startup_props.sv ***
`timescale 1ns/1ps
module css_clock_startup_props
  import css_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0]  factoryTrim,
  input wire logic [3:0]  oscEnable,
  input wire logic [7:0]  oscillatorTrimValue,
  input wire logic [3:0]  prescalerDivideSelect,
  input wire logic        sysClkRun
);
  logic [15:0] lowCnt_ff;
  // Saturates so a long stall never wraps into a false short delay.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) lowCnt_ff <= 16'h0000;
    else if (sysClkRun) lowCnt_ff <= 16'h0000;
    else if (lowCnt_ff != 16'hffff) lowCnt_ff <= lowCnt_ff + 16'h0001;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence bAnswer;
    ##[1:2] s_axi_bvalid;
  endsequence
  a_write_answer: assert property (wrTaken |-> bAnswer)
    else $error("Write response missing.");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read data missing.");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped.");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped.");
  a_aw_stalls: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write taken before response.");
  a_trim_reload: assert property ($rose(rst_b)
    |=> oscillatorTrimValue == $past(factoryTrim))
    else $error("Trim not loaded.");
  a_reset_default: assert property ($rose(rst_b)
    |=> prescalerDivideSelect == 4'h3 && oscEnable == 4'h2)
    else $error("Wrong start-up defaults.");
  a_onehot_src: assert property ($onehot0(oscEnable))
    else $error("Two sources enabled.");
  a_delay_floor: assert property ($rose(sysClkRun) |-> lowCnt_ff >= 16'h000e)
    else $error("Clock released too early.");
endmodule
bind css_clock_startup css_clock_startup_props u_props (.mclk, .rst_b, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .factoryTrim,
  .oscEnable, .oscillatorTrimValue, .prescalerDivideSelect, .sysClkRun);

// *** bench/tb_clock_source_startup_select.sv ***
`timescale 1ns/1ps
`include "css_map.svh"
`define CHK(n, e, a) begin \
  checks++; \
  if ((a) !== (e)) begin \
    n_fail++; \
    $display("Error %s exp %h got %h", n, e, a); \
  end \
end
module tb_clock_source_startup_select
  import css_pkg::*;
;
  logic        mclk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, wakePin, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, sysClkRun, sysTick, coreReset;
  logic        timerOscillatorPin, rcOscillator, lowPowerOscillator;
  logic        crystalInputPin, watchdogOscillator;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, factoryTrim, oscillatorTrimValue;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, oscEnable, prescalerDivideSelect;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          checks = 0, n_fail = 0, cyc = 0;
  always #12.5 mclk = ~mclk;
  css_osc_model OSC (.timerOscillatorPin, .rcOscillator, .lowPowerOscillator,
    .crystalInputPin, .watchdogOscillator);
  // The 65 ms and 64 ms counts are shortened to 20 watchdog edges to keep the run brief.
  css_clock_startup #(.WDT_CYC_65MS(20), .WDT_CYC_64MS(20), .SRC_CYC_32K(40)) DUT (
    .mclk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .timerOscillatorPin,
    .rcOscillator, .lowPowerOscillator, .crystalInputPin, .watchdogOscillator, .wakePin,
    .factoryTrim, .oscEnable, .oscillatorTrimValue, .prescalerDivideSelect, .sysClkRun,
    .sysTick, .coreReset);
  task print_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // Counting starts only once the clock has dropped, so sync lag is in the slack.
  task automatic waitRun(input logic wake, output int n);
    n = 0;
    while (sysClkRun !== 1'b0) @(posedge mclk);
    if (wake) wakePin <= 1'b1;
    while (sysClkRun !== 1'b1) begin
      @(posedge mclk);
      n++;
    end
    wakePin <= 1'b0;
  endtask
  function automatic logic inRange(input int n, input int e, input int p);
    return n >= (e - 1) * p / 25 - 4 && n <= (e + 4) * p / 25 + 12;
  endfunction
  task automatic tSrc(input logic [7:0] f, input int re, rp, we, wp, input logic [3:0] en);
    int n;
    logic [31:0] d;
    logic [1:0] r;
    wr(`CSS_OFF_FUSE, {24'h0, f}, r);
    wr(`CSS_OFF_CTRL, 32'h1, r);
    waitRun(1'b0, n);
    `CHK("reset delay", 1'b1, inRange(n, re, rp))
    `CHK("osc enable", en, oscEnable)
    `CHK("prescale", f[6] ? 4'h3 : 4'h0, prescalerDivideSelect)
    `CHK("trim", factoryTrim, oscillatorTrimValue)
    `CHK("core reset", 1'b0, coreReset)
    rd(`CSS_OFF_STATUS, d, r);
    `CHK("status", 32'h0000000a | ($clog2(en) << 5), d)
    wr(`CSS_OFF_CTRL, 32'h2, r);
    waitRun(1'b1, n);
    `CHK("wake delay", 1'b1, inRange(n, we, wp))
  endtask
  initial begin
    int n;
    logic [31:0] d;
    logic [1:0] r;
    mclk = 1'b0;
    rst_b = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, wakePin} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    factoryTrim = 8'h5a;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    waitRun(1'b0, n);
    `CHK("boot delay", 1'b1, inRange(n, 20, 200))
    `CHK("boot trim", 8'h5a, oscillatorTrimValue)
    `CHK("boot prescale", 4'h3, prescalerDivideSelect)
    rd(`CSS_OFF_FUSE, d, r);
    `CHK("fuse default", 32'h00000062, d)
    wr(`CSS_OFF_TRIM, 32'hc3, r);
    rd(`CSS_OFF_TRIM, d, r);
    `CHK("trim read", 32'h000000c3, d)
    `CHK("trim port", 8'hc3, oscillatorTrimValue)
    wr(`CSS_OFF_PRESCALE, 32'h1, r);
    `CHK("prescale write", 4'h1, prescalerDivideSelect)
    // Divide by two on the 100 ns RC clock gives one tick per 200 ns.
    n = 0;
    repeat (400) begin
      @(posedge mclk);
      if (sysTick === 1'b1) n++;
    end
    `CHK("tick rate", 1'b1, n >= 48 && n <= 51)
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    waitRun(1'b0, n);
    `CHK("reset trim", 8'h5a, oscillatorTrimValue)
    `CHK("reset prescale", 4'h3, prescalerDivideSelect)
    rd(8'h20, d, r);
    `CHK("unmapped rresp", `CSS_RESP_SLVERR, r)
    wr(8'h20, 32'h1, r);
    `CHK("unmapped bresp", `CSS_RESP_SLVERR, r)
    factoryTrim <= 8'h3c;
    wr(`CSS_OFF_FUSE, 32'h04, r);
    wr(`CSS_OFF_CTRL, 32'h1, r);
    repeat (8) @(posedge mclk);
    `CHK("bad code enable", 4'h0, oscEnable)
    `CHK("bad core reset", 1'b1, coreReset)
    rd(`CSS_OFF_STATUS, d, r);
    `CHK("bad code flag", 1'b1, d[4])
    tSrc(8'h00, 14, 120, 6, 120, 4'h8);
    tSrc(8'h42, 14, 100, 6, 100, 4'h2);
    tSrc(8'h03, 14, 150, 6, 150, 4'h4);
    tSrc(8'h06, 4, 220, 1024, 220, 4'h1);
    tSrc(8'h47, 4, 220, 40, 220, 4'h1);
    tSrc(8'h17, 525, 200, 40, 220, 4'h1);
    tSrc(8'h12, 525, 200, 6, 100, 4'h2);
    tSrc(8'h13, 512, 200, 6, 150, 4'h4);
    tSrc(8'h20, 20, 200, 6, 120, 4'h8);
    tSrc(8'h32, 20, 200, 6, 100, 4'h2);
    tSrc(8'h82, 525, 200, 6, 100, 4'h2);
    tSrc(8'h83, 525, 200, 6, 150, 4'h4);
    tSrc(8'h80, 14, 120, 6, 120, 4'h8);
    print_verdict();
  end
endmodule
